/* File: adc_ctrl_map.vh */
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH
`define HW_TRIG_PIN      2'h0
`define HW_TRIG_TB2      2'h1
`define HW_TRIG_TA0      2'h2
`define EXT_NONE         2'h0
`define EXT_PIN_A        2'h1
`define EXT_PIN_B        2'h2
`define EXT_AMP          2'h3
`define SAMPLE_CYC_PLAIN 4'h2
`define SAMPLE_CYC_HOLD  4'h3
`define CONV_CYC_8       6'h08
`define CONV_CYC_10      6'h0A
`define RES_BITS         10
`endif

/* File: result_buffer.v */
`timescale 1ns/1ps
module result_buffer
#(
   parameter WIDTH = 14
)
(
   input  wire             clk_sys_in,
   input  wire             sys_rst_in,
   input  wire             in_valid_in,
   output wire             in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   output reg              out_valid_out,
   input  wire             out_ready_in,
   output reg  [WIDTH-1:0] out_data_out
);
   // two entries: main register plus skid, so a stall loses nothing until both are full
   reg             skid_valid;
   reg [WIDTH-1:0] skid_data;
   reg             ready;
   assign in_ready_out = ready;
   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         out_valid_out <= 1'b0;
         out_data_out  <= {WIDTH{1'b0}};
         skid_valid    <= 1'b0;
         skid_data     <= {WIDTH{1'b0}};
         ready         <= 1'b1;
      end
      else
      begin
         if (!out_valid_out || out_ready_in)
         begin
            if (skid_valid)
            begin
               out_valid_out <= 1'b1;
               out_data_out  <= skid_data;
               skid_valid    <= 1'b0;
               ready         <= 1'b1;
            end
            else
            begin
               out_valid_out <= in_valid_in && ready;
               if (in_valid_in && ready)
                  out_data_out <= in_data_in;
            end
         end
         else if (in_valid_in && ready)
         begin
            skid_valid <= 1'b1;
            skid_data  <= in_data_in;
            ready      <= 1'b0;
         end
      end
   end
endmodule

/* File: adc_trigger_and_mode_control.v */
`timescale 1ns/1ps
`include "adc_ctrl_map.vh"
module adc_trigger_and_mode_control
(
   input  wire       clk_sys_in,
   input  wire       sys_rst_in,
   input  wire       trigger_source_select_in,
   input  wire       hw_trigger_sel_hi_in,
   input  wire       hw_trigger_sel_lo_in,
   input  wire       conversion_start_bit_in,
   input  wire       dma_mode_enable_in,
   input  wire       one_shot_or_repeat_in,
   input  wire       ext_input_sel_hi_in,
   input  wire       ext_input_sel_lo_in,
   input  wire [2:0] channel_sel_in,
   input  wire       resolution_10_in,
   input  wire       sample_hold_in,
   input  wire       assist_enable_in,
   input  wire       assist_select_in,
   input  wire       assist_method_in,
   input  wire       reference_connect_bit_in,
   input  wire       ext_trigger_pin_in,
   input  wire       timer_b2_div_req_in,
   input  wire       timer_a0_req_in,
   input  wire       comparator_in,
   input  wire       dma_ready_in,
   output reg        sampling_out,
   output reg        converting_out,
   output reg        busy_out,
   output reg  [2:0] sample_channel_out,
   output reg        extra_pin_a_in_en_out,
   output reg        extra_pin_b_in_en_out,
   output reg        extra_pin_a_drive_out,
   output reg        assist_pull_up_out,
   output reg        assist_pull_down_out,
   output reg        assist_force_vcc_out,
   output reg        assist_force_gnd_out,
   output reg        ladder_connect_out,
   output reg        result_valid_out,
   output reg  [2:0] result_index_out,
   output reg  [15:0] result_data_out,
   output reg        dma_request_out,
   output reg        conv_done_irq_out,
   output reg        result_dropped_out
);
   localparam IDLE   = 2'h0;
   localparam SAMPLE = 2'h1;
   localparam CONV   = 2'h2;
   localparam STORE  = 2'h3;

   reg [1:0]  state;
   reg [3:0]  cnt;
   reg [9:0]  sar;
   reg [9:0]  trial;
   reg [2:0]  target;
   reg        pin_meta;
   reg        pin_sync;
   reg        pin_prev;
   reg        tb2_prev;
   reg        ta0_prev;
   reg        start_prev;
   wire       pin_fall;
   wire       tb2_pulse;
   wire       ta0_pulse;
   wire       sw_start;
   wire [1:0] hw_sel;
   wire [1:0] ext_sel;
   wire [1:0] ext_eff;
   reg        hw_trig;
   wire       in_ready;
   wire       fifo_valid;
   wire [13:0] fifo_data;

   assign hw_sel  = {hw_trigger_sel_hi_in, hw_trigger_sel_lo_in};
   assign ext_sel = {ext_input_sel_hi_in, ext_input_sel_lo_in};
   assign ext_eff = one_shot_or_repeat_in ? ext_sel : `EXT_NONE;

   // pin is asynchronous; only the second and third stages feed edge logic
   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         pin_meta   <= 1'b1;
         pin_sync   <= 1'b1;
         pin_prev   <= 1'b1;
         tb2_prev   <= 1'b0;
         ta0_prev   <= 1'b0;
         start_prev <= 1'b0;
      end
      else
      begin
         pin_meta   <= ext_trigger_pin_in;
         pin_sync   <= pin_meta;
         pin_prev   <= pin_sync;
         tb2_prev   <= timer_b2_div_req_in;
         ta0_prev   <= timer_a0_req_in;
         start_prev <= conversion_start_bit_in;
      end
   end
   assign pin_fall  = pin_prev & ~pin_sync;
   // level held high counts once only
   assign tb2_pulse = timer_b2_div_req_in & ~tb2_prev;
   assign ta0_pulse = timer_a0_req_in & ~ta0_prev;
   assign sw_start  = !trigger_source_select_in &&
                      conversion_start_bit_in && !start_prev;

   always @*
   begin
      hw_trig = 1'b0;
      if (trigger_source_select_in && conversion_start_bit_in)
      begin
         if (hw_sel == `HW_TRIG_PIN)
            hw_trig = pin_fall && !dma_mode_enable_in;
         else if (hw_sel == `HW_TRIG_TB2)
            hw_trig = tb2_pulse;
         else if (hw_sel == `HW_TRIG_TA0)
            hw_trig = ta0_pulse;
      end
   end

   // result routing target
   always @*
   begin
      if (dma_mode_enable_in)
         target = 3'h0;
      else if (ext_eff == `EXT_PIN_A)
         target = 3'h0;
      else if (ext_eff == `EXT_PIN_B)
         target = 3'h1;
      else
         target = channel_sel_in;
   end

   always @*
   begin
      trial = 10'h000;
      if (resolution_10_in)
         trial = sar | (10'h200 >> cnt);
      else
         trial = sar | (10'h080 >> cnt);
   end

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         state          <= IDLE;
         cnt            <= 4'h0;
         sar            <= 10'h000;
         sampling_out   <= 1'b0;
         converting_out <= 1'b0;
         busy_out       <= 1'b0;
      end
      else if (!conversion_start_bit_in)
      begin
         state          <= IDLE;
         sampling_out   <= 1'b0;
         converting_out <= 1'b0;
         busy_out       <= 1'b0;
      end
      else if (sw_start || hw_trig)
      begin
         state          <= SAMPLE;
         cnt            <= 4'h1;
         sar            <= 10'h000;
         sampling_out   <= 1'b1;
         converting_out <= 1'b0;
         busy_out       <= 1'b1;
      end
      else
      begin
         case (state)
            SAMPLE:
            begin
               if (cnt == (sample_hold_in ? `SAMPLE_CYC_HOLD
                                          : `SAMPLE_CYC_PLAIN))
               begin
                  state          <= CONV;
                  cnt            <= 4'h0;
                  sampling_out   <= 1'b0;
                  converting_out <= 1'b1;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            CONV:
            begin
               // comparator reports input above trial level
               sar <= comparator_in ? trial : sar;
               if ({2'h0, cnt} == (resolution_10_in ? `CONV_CYC_10
                                   : `CONV_CYC_8) - 6'h01)
               begin
                  state          <= STORE;
                  converting_out <= 1'b0;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            STORE:
            begin
               state    <= IDLE;
               busy_out <= 1'b0;
            end
            default:
               state <= IDLE;
         endcase
      end
   end

   // fifo absorbs dma stalls; a full buffer drops and flags
   result_buffer #(.WIDTH(14)) u_buf
   (
      .clk_sys_in    (clk_sys_in),
      .sys_rst_in    (sys_rst_in),
      .in_valid_in   (state == STORE),
      .in_ready_out  (in_ready),
      .in_data_in    ({target, resolution_10_in, sar}),
      .out_valid_out (fifo_valid),
      .out_ready_in  (dma_ready_in || !dma_mode_enable_in),
      .out_data_out  (fifo_data)
   );

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         result_valid_out   <= 1'b0;
         result_index_out   <= 3'h0;
         result_data_out    <= 16'h0000;
         dma_request_out    <= 1'b0;
         conv_done_irq_out  <= 1'b0;
         result_dropped_out <= 1'b0;
      end
      else
      begin
         result_valid_out   <= fifo_valid &&
                               (dma_ready_in || !dma_mode_enable_in);
         dma_request_out    <= fifo_valid && dma_ready_in &&
                               dma_mode_enable_in;
         conv_done_irq_out  <= fifo_valid && dma_ready_in &&
                               dma_mode_enable_in;
         result_dropped_out <= (state == STORE) && !in_ready;
         if (fifo_valid)
         begin
            result_index_out <= fifo_data[13:11];
            if (fifo_data[10])
               result_data_out <= {6'h00, fifo_data[9:0]};
            else
               result_data_out <= {8'h00, fifo_data[7:0]};
         end
      end
   end

   // analog steering follows configuration directly
   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         sample_channel_out    <= 3'h0;
         extra_pin_a_in_en_out <= 1'b0;
         extra_pin_b_in_en_out <= 1'b0;
         extra_pin_a_drive_out <= 1'b0;
         assist_pull_up_out    <= 1'b0;
         assist_pull_down_out  <= 1'b0;
         assist_force_vcc_out  <= 1'b0;
         assist_force_gnd_out  <= 1'b0;
         ladder_connect_out    <= 1'b0;
      end
      else
      begin
         sample_channel_out    <= channel_sel_in;
         extra_pin_a_in_en_out <= (ext_eff == `EXT_PIN_A);
         extra_pin_b_in_en_out <= (ext_eff == `EXT_PIN_B) ||
                                  (ext_eff == `EXT_AMP);
         extra_pin_a_drive_out <= (ext_eff == `EXT_AMP);
         assist_pull_up_out    <= assist_enable_in && !assist_select_in &&
                                  !assist_method_in;
         assist_pull_down_out  <= assist_enable_in && !assist_select_in &&
                                  assist_method_in;
         assist_force_vcc_out  <= assist_enable_in && assist_select_in &&
                                  !assist_method_in;
         assist_force_gnd_out  <= assist_enable_in && assist_select_in &&
                                  assist_method_in;
         // a/d ladder only; d/a reference is not touched here
         ladder_connect_out    <= reference_connect_bit_in;
      end
   end
endmodule

/* File: adc_ctrl_properties.sv */
`timescale 1ns/1ps
module adc_ctrl_checker
(
   input wire        clk_sys_in,
   input wire        sys_rst_in,
   input wire        trigger_source_select_in,
   input wire        hw_trigger_sel_hi_in,
   input wire        hw_trigger_sel_lo_in,
   input wire        conversion_start_bit_in,
   input wire        dma_mode_enable_in,
   input wire        resolution_10_in,
   input wire        sample_hold_in,
   input wire        reference_connect_bit_in,
   input wire        ext_trigger_pin_in,
   input wire        timer_b2_div_req_in,
   input wire        timer_a0_req_in,
   input wire        sampling_out,
   input wire        converting_out,
   input wire        busy_out,
   input wire        ladder_connect_out,
   input wire        result_valid_out,
   input wire [2:0]  result_index_out,
   input wire [15:0] result_data_out,
   input wire        dma_request_out,
   input wire        conv_done_irq_out,
   input wire        result_dropped_out
);
   reg [4:0] conv_run;
   wire [1:0] hw = {hw_trigger_sel_hi_in, hw_trigger_sel_lo_in};
   // run length of converting, reset by any gap
   always @(posedge clk_sys_in)
   begin
      conv_run <= converting_out ? conv_run + 5'h01 : 5'h00;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   a_samp_plain: assert property ($rose(converting_out) |->
      $past(sampling_out) && $past(sampling_out, 2))
      else $error("short sample");
   a_samp_hold: assert property ($rose(converting_out) &&
      sample_hold_in |-> $past(sampling_out, 3))
      else $error("short held sample");
   a_conv_len: assert property ($fell(converting_out) &&
      !sampling_out && $past(conversion_start_bit_in) |->
      conv_run == (resolution_10_in ? 5'h0A : 5'h08))
      else $error("bad conversion length");
   a_stop_abort: assert property (!conversion_start_bit_in |=>
      !busy_out && !sampling_out) else $error("busy while stopped");
   a_sw_start: assert property (!trigger_source_select_in &&
      $rose(conversion_start_bit_in) && !$past(sys_rst_in) |=> sampling_out)
      else $error("software start missed");
   a_timer_start: assert property (
      trigger_source_select_in && conversion_start_bit_in &&
      (hw == 2'h1 && $rose(timer_b2_div_req_in) ||
      hw == 2'h2 && $rose(timer_a0_req_in)) |=> sampling_out)
      else $error("timer trigger missed");
   a_pin_start: assert property (
      trigger_source_select_in && hw == 2'h0 &&
      conversion_start_bit_in && !dma_mode_enable_in &&
      $fell(ext_trigger_pin_in) |-> ##[1:5] sampling_out)
      else $error("pin trigger missed");
   a_dma_index: assert property (result_valid_out &&
      dma_mode_enable_in |-> result_index_out == 3'h0)
      else $error("dma result not in slot 0");
   a_irq_dma: assert property (conv_done_irq_out |->
      dma_mode_enable_in && dma_request_out)
      else $error("stray completion");
   a_res_narrow: assert property (result_valid_out &&
      !resolution_10_in |-> result_data_out[15:8] == 8'h00)
      else $error("8-bit result too wide");
   a_ladder_follow: assert property (!$past(sys_rst_in) |->
      ladder_connect_out == $past(reference_connect_bit_in))
      else $error("ladder does not follow connect bit");
   c_done: cover property ($fell(converting_out) && !sampling_out);
   c_restart: cover property ($rose(sampling_out) && $past(busy_out));
   c_dma: cover property (dma_request_out);
   c_drop: cover property (result_dropped_out);
endmodule

/* File: dma_drain_model.sv */
`timescale 1ns/1ps
module dma_drain_model
(
   input  wire       clk_sys_in,
   input  wire       stall_in,
   input  wire       request_in,
   input  wire       wide_in,
   output reg        ready_out = 1'b0,
   output reg  [4:0] width_out = 5'h08
);
   // a real drain is not always ready: skip one slot in three
   always @(posedge clk_sys_in)
   begin
      ready_out <= !stall_in && ($urandom % 3 != 0);
      if (request_in)
         width_out <= wide_in ? 5'h10 : 5'h08;
   end
endmodule

/* File: test_adc_trigger_and_mode_control.sv */
`timescale 1ns/1ps
module test_adc_trigger_and_mode_control;
   reg clk_sys_in = 1'b0, sys_rst_in = 1'b1, trig_src = 1'b0, hw_hi = 1'b0;
   reg hw_lo = 1'b0, start = 1'b0, dma_en = 1'b0, one_shot = 1'b0;
   reg ext_hi = 1'b0, ext_lo = 1'b0, res10 = 1'b0, hold = 1'b0, ast_en = 1'b0;
   reg ast_sel = 1'b0, ast_mtd = 1'b0, ref_on = 1'b0, pin = 1'b1, tb2 = 1'b0;
   reg ta0 = 1'b0, cmp = 1'b0, stall = 1'b0;
   reg [2:0] chan = 3'h0;
   reg [31:0] r;
   wire rdy, samp, conv, busy, pa_in, pb_in, pa_drv, pu, pd, fv, fg, ladder;
   wire rvalid, dreq, irq, drop;
   wire [2:0] ridx, schan;
   wire [4:0] dwidth;
   wire [15:0] rdata;
   integer num_errors = 0, tests_run = 0, nres = 0, ndrop = 0, nirq = 0;
   integer i, k0, d0, nreq = 0;
   adc_trigger_and_mode_control DUT (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .trigger_source_select_in(trig_src),
      .hw_trigger_sel_hi_in(hw_hi), .hw_trigger_sel_lo_in(hw_lo),
      .conversion_start_bit_in(start), .dma_mode_enable_in(dma_en),
      .one_shot_or_repeat_in(one_shot), .ext_input_sel_hi_in(ext_hi),
      .ext_input_sel_lo_in(ext_lo), .channel_sel_in(chan),
      .resolution_10_in(res10), .sample_hold_in(hold),
      .assist_enable_in(ast_en), .assist_select_in(ast_sel),
      .assist_method_in(ast_mtd), .reference_connect_bit_in(ref_on),
      .ext_trigger_pin_in(pin), .timer_b2_div_req_in(tb2),
      .timer_a0_req_in(ta0), .comparator_in(cmp), .dma_ready_in(rdy),
      .sampling_out(samp), .converting_out(conv), .busy_out(busy),
      .sample_channel_out(schan), .extra_pin_a_in_en_out(pa_in),
      .extra_pin_b_in_en_out(pb_in), .extra_pin_a_drive_out(pa_drv),
      .assist_pull_up_out(pu), .assist_pull_down_out(pd),
      .assist_force_vcc_out(fv), .assist_force_gnd_out(fg),
      .ladder_connect_out(ladder), .result_valid_out(rvalid),
      .result_index_out(ridx), .result_data_out(rdata),
      .dma_request_out(dreq), .conv_done_irq_out(irq),
      .result_dropped_out(drop));
   dma_drain_model drain (.clk_sys_in(clk_sys_in), .stall_in(stall),
      .request_in(dreq), .wide_in(res10), .ready_out(rdy), .width_out(dwidth));
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in)
   begin
      nres <= nres + rvalid;
      nreq <= nreq + dreq;
      ndrop <= ndrop + drop;
      nirq <= nirq + irq;
   end
   task chk(input [8*8:1] name, input [15:0] seen, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp)
         begin
            num_errors = num_errors + 1;
            $display("unexpected %0s exp %h seen %h", name, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   // one-cycle trigger pulse; pin idles high
   task fire(input integer s);
      begin
         @(posedge clk_sys_in);
         if (s == 0) pin <= 1'b0;
         else if (s == 1) tb2 <= 1'b1;
         else ta0 <= 1'b1;
         @(posedge clk_sys_in);
         pin <= 1'b1;
         tb2 <= 1'b0;
         ta0 <= 1'b0;
      end
   endtask
   // counts sampling and converting cycles up to the result
   task run(input [2:0] ei, input [15:0] es, input [15:0] ec);
      integer k, ns, nc;
      begin
         k = 0; ns = 0; nc = 0;
         #1;
         while (!rvalid && k < 200)
         begin
            ns = ns + samp; nc = nc + conv;
            @(posedge clk_sys_in);
            #1;
            k = k + 1;
         end
         if (k == 200)
         begin
            num_errors = num_errors + 1;
            print_verdict;
         end
         chk("sample", ns[15:0], es);
         chk("conv", nc[15:0], ec);
         chk("index", {13'h0000, ridx}, {13'h0000, ei});
      end
   endtask
   function [2:0] exp_idx(input d, input o, input h, input l, input [2:0] c);
      exp_idx = d ? 3'h0 : !o ? c : (l & !h) ? 3'h0 : (h & !l) ? 3'h1 : c;
   endfunction
   function [7:0] exp_pins(input [6:0] v);
      exp_pins = {v[6] & !v[5] & v[4], v[6] & v[5], v[6] & v[5] & v[4],
         v[3] & !v[2] & !v[1], v[3] & !v[2] & v[1], v[3] & v[2] & !v[1],
         v[3] & v[2] & v[1], v[0]};
   endfunction
   initial
   begin
      r = $urandom(17);
      cyc(2);
      sys_rst_in <= 1'b0;
      for (i = 0; i < 40; i = i + 1)
      begin
         @(posedge clk_sys_in);
         r = $urandom;
         {one_shot, ext_hi, ext_lo, ast_en, ast_sel, ast_mtd, ref_on} <= r[6:0];
         chan <= r[9:7];
         cyc(2);
         #1;
         chk("pins",
            {8'h00, pa_in, pb_in, pa_drv, pu, pd, fv, fg, ladder},
            {8'h00, exp_pins(r[6:0])});
         chk("chan", {13'h0000, schan}, {13'h0000, r[9:7]});
      end
      $display("static pin map done");
      @(posedge clk_sys_in);
      ref_on <= 1'b1;
      cyc(100);
      for (i = 0; i < 12; i = i + 1)
      begin
         @(posedge clk_sys_in);
         r = $urandom;
         start <= 1'b0;
         dma_en <= i[3];
         {hold, res10} <= i[1:0];
         {one_shot, ext_hi, ext_lo, chan} <= r[5:0];
         cmp <= r[6];
         @(posedge clk_sys_in);
         start <= 1'b1;
         run(exp_idx(i[3], r[5], r[4], r[3], r[2:0]),
            hold ? 3 : 2, res10 ? 10 : 8);
         chk("data", rdata, r[6] ? (res10 ? 16'h03FF : 16'h00FF)
            : 16'h0000);
      end
      cyc(3);
      chk("irqs", nirq[15:0], 16'h0004);
      chk("reqs", nreq[15:0], 16'h0004);
      chk("width", {11'h000, dwidth}, 16'h0010);
      $display("software start done");
      stall <= 1'b1;
      d0 = ndrop;
      k0 = nres;
      for (i = 0; i < 4; i = i + 1)
      begin
         @(posedge clk_sys_in);
         start <= 1'b0;
         @(posedge clk_sys_in);
         start <= 1'b1;
         cyc(16);
      end
      cyc(2);
      chk("drops", ndrop - d0, 16'h0002);
      stall <= 1'b0;
      cyc(20);
      chk("drain", nres - k0, 16'h0002);
      $display("stalled drain done");
      {dma_en, trig_src, res10, hold, one_shot} <= 5'h0C;
      for (i = 0; i < 3; i = i + 1)
      begin
         @(posedge clk_sys_in);
         start <= 1'b0;
         {hw_hi, hw_lo} <= i[1:0];
         fire(i);
         cyc(6);
         chk("ignore", {15'h0000, busy}, 16'h0000);
         start <= 1'b1;
         cyc(3);
         fire(i);
         run(chan, 2, 10);
      end
      $display("hardware triggers done");
      cyc(3);
      fire(2);
      cyc(5);
      k0 = nres;
      fire(2);
      run(chan, 2, 10);
      cyc(2);
      chk("restart", nres - k0, 16'h0001);
      $display("restart done");
      print_verdict;
   end
endmodule
bind adc_trigger_and_mode_control adc_ctrl_checker u_chk (.*);
